// *** bench/pml_mac_model.sv ***
// Controller model on the transmit side of the MII timing core.
// Assumes the bench calls send; the transmit clock runs free.
`timescale 1ns/1ps
module pml_mac_model (
    // Transmit side
    output logic tx_clk_o,
    output logic tx_en_o,
    output logic [3:0] txd_o
);
    initial begin
        tx_clk_o = 1'b0;
        tx_en_o = 1'b0;
        txd_o = 4'h0;
    end
    always #62.5 tx_clk_o = ~tx_clk_o;
    // Updating just after the rise keeps data settled for either capture edge.
    task automatic send(input logic [3:0] nib, input int n);
        repeat (n) begin
            @(posedge tx_clk_o);
            #1;
            tx_en_o = 1'b1;
            txd_o = nib;
            nib = nib + 4'h1;
        end
        @(posedge tx_clk_o);
        #1;
        tx_en_o = 1'b0;
        txd_o = ~txd_o;
    endtask : send
endmodule : pml_mac_model

// *** bench/pml_phy_timing_sva.sv ***
// Assertions on the ports of the MII timing core.
// Assumes the bench changes inputs just after the rising clock edge.
`timescale 1ns/1ps
module pml_phy_timing_sva
    import pml_pkg::*;
#(
    parameter int unsigned STRAP_CYC = STRAP_DRIVE_CYC,
    parameter int unsigned W = 4
) (
    // Clock, reset and mode
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [15:0] sw_strap_ctrl_reg_one_i,
    input wire logic speed_100_i,
    // Watched pins
    input wire logic [W-1:0] strap_pin_o,
    input wire logic [W-1:0] strap_pin_oe_o,
    input wire logic [W-1:0] strap_val_o,
    input wire logic tx_en_i,
    input wire logic line_tx_o,
    input wire logic line_rx_act_i,
    input wire logic rx_clk_o,
    input wire logic crs_o,
    input wire logic rx_dv_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [15:0] cnt_q;
    logic [7:0] len_q;
    logic clk_q;
    logic act_q;
    logic rx_on;
    logic fast;
    // The first clock phase after reset is not judged, as its start is unknown.
    always_ff @(posedge sys_clk_i) begin
        clk_q <= rx_clk_o;
        act_q <= line_rx_act_i;
        cnt_q <= !nrst_i ? 16'h0 : cnt_q + {15'h0, cnt_q != 16'hffff};
        len_q <= !nrst_i ? 8'hff : rx_clk_o != clk_q ? 8'h1 : len_q + {7'h0, len_q != 8'hff};
    end
    assign rx_on = speed_100_i && line_rx_act_i && !act_q;
    assign fast = sw_strap_ctrl_reg_one_i[FAST_VALID_DETECT_BIT];
    AST_STRAP_EARLY: assert property (|strap_pin_oe_o |-> cnt_q >= STRAP_CYC - 1)
        else $error("strap pins driven early");
    AST_STRAP_DRIVE: assert property (
        cnt_q == STRAP_CYC + 4 |-> &strap_pin_oe_o && strap_pin_o == strap_val_o)
        else $error("strap pins not driving latched value");
    AST_RXC_PHASE: assert property (
        rx_clk_o != clk_q |-> len_q >= (speed_100_i ? RXC_HALF_100_CYC : RXC_HALF_10_CYC))
        else $error("receive clock phase too short");
    AST_TX_START: assert property (
        speed_100_i && $rose(tx_en_i) |-> ##[34:42] $rose(line_tx_o))
        else $error("line start off time");
    AST_TX_END: assert property (
        speed_100_i && $fell(tx_en_i) |-> ##[34:42] $fell(line_tx_o))
        else $error("line end off time");
    AST_CRS_ON: assert property (rx_on |-> ##[28:34] $rose(crs_o))
        else $error("carrier sense rise off time");
    AST_RX_NORMAL: assert property (rx_on && !fast |-> ##[40:50] $rose(rx_dv_o))
        else $error("normal receive latency wrong");
    AST_RX_FAST: assert property (rx_on && fast |-> ##[32:42] $rose(rx_dv_o))
        else $error("fast receive latency wrong");
    AST_CRS_OFF: assert property (
        speed_100_i && $fell(line_rx_act_i) |-> ##[38:44] $fell(crs_o))
        else $error("carrier sense fall off time");
    CV_STRAP: cover property ($rose(|strap_pin_oe_o));
    CV_FAST: cover property ($rose(rx_dv_o) && fast);
    CV_TX: cover property ($fell(line_tx_o));
endmodule : pml_phy_timing_sva
bind pml_phy_timing pml_phy_timing_sva #(.STRAP_CYC(STRAP_CYC), .W(W)) u_pml_phy_timing_sva (
    .sys_clk_i, .nrst_i, .sw_strap_ctrl_reg_one_i, .speed_100_i, .strap_pin_o, .strap_pin_oe_o,
    .strap_val_o, .tx_en_i, .line_tx_o, .line_rx_act_i, .rx_clk_o, .crs_o, .rx_dv_o);

// *** bench/pml_phy_timing_tb.sv ***
// Self-checking bench for the MII timing core.
// Assumes a 200 MHz system clock and the controller model on the transmit side.
`timescale 1ns/1ps
module pml_phy_timing_tb;
    localparam int unsigned STRAP_SIM = 50;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] sw_strap_ctrl_reg_one_i = 16'h0;
    logic speed_100_i = 1'b1;
    logic rx_recovered_sel_i = 1'b0;
    logic [3:0] strap_pin_i = 4'h5;
    logic line_rx_act_i = 1'b0;
    logic [3:0] line_rxd_i = 4'h0;
    logic rx_ready_i = 1'b1;
    logic tx_clk_i, tx_en_i, line_tx_o, rx_clk_o, crs_o, rx_dv_o;
    logic [3:0] txd_i, strap_pin_o, strap_pin_oe_o, strap_val_o, line_txd_o, rxd_o;
    int error_cnt = 0;
    int checked = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    pml_mac_model u_pml_mac_model (.tx_clk_o(tx_clk_i), .tx_en_o(tx_en_i), .txd_o(txd_i));
    pml_phy_timing #(.STRAP_CYC(STRAP_SIM)) u_pml_phy_timing (.sys_clk_i, .nrst_i,
        .sw_strap_ctrl_reg_one_i, .speed_100_i, .rx_recovered_sel_i, .strap_pin_i, .strap_pin_o,
        .strap_pin_oe_o, .strap_val_o, .tx_clk_i, .tx_en_i, .txd_i, .line_tx_o, .line_txd_o,
        .line_rx_act_i, .line_rxd_i, .rx_clk_o, .crs_o, .rx_dv_o, .rxd_o, .rx_ready_i);
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : cyc
    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic results();
        $display("compared %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task automatic wait_hi(input bit tx, input int lim);
        int i;
        for (i = 0; i < lim && (tx ? line_tx_o : rx_dv_o) !== 1'b1; i++)
            cyc(1);
        if (i >= lim) begin
            error_cnt++;
            results();
        end
    endtask : wait_hi
    task automatic reset(input logic spd);
        nrst_i = 1'b0;
        speed_100_i = spd;
        cyc(4);
        nrst_i = 1'b1;
    endtask : reset
    task automatic t_strap();
        reset(1'b1);
        cyc(STRAP_SIM - 10);
        check(strap_pin_oe_o, 4'h0, "strap pins driven early");
        cyc(20);
        check(strap_pin_oe_o, 4'hf, "strap pins not driven");
        check(strap_pin_o, 4'h5, "strap value");
        check(strap_val_o, 4'h5, "latched strap value");
        $display("test strap done");
    endtask : t_strap
    // A 10-cycle receiver stall in mid-packet overflows the two-entry buffer; the data before and after the stall is checked.
    task automatic t_rx(input logic fast);
        reset(1'b1);
        sw_strap_ctrl_reg_one_i = {14'h0, fast, 1'b0};
        line_rxd_i = 4'ha;
        line_rx_act_i = 1'b1;
        rx_recovered_sel_i = 1'b1;
        wait_hi(1'b0, 80);
        check(crs_o, 4'h1, "carrier sense");
        check(rxd_o, 4'ha, "receive data");
        rx_ready_i = 1'b0;
        cyc(10);
        rx_ready_i = 1'b1;
        wait_hi(1'b0, 20);
        check(rxd_o, 4'ha, "data after stall");
        line_rx_act_i = 1'b0;
        line_rxd_i = 4'h5;
        rx_recovered_sel_i = 1'b0;
        cyc(60);
        check(crs_o, 4'h0, "carrier sense held");
        $display("test receive done");
    endtask : t_rx
    task automatic t_tx(input logic spd, input logic [3:0] nib);
        reset(spd);
        fork
            u_pml_mac_model.send(nib, 4);
        join_none
        wait_hi(1'b1, 300);
        check(line_txd_o, nib, "first line nibble");
        cyc(300);
        check(line_tx_o, 4'h0, "line still sending");
        $display("test transmit done");
    endtask : t_tx
    initial begin
        t_strap();
        t_rx(1'b0);
        t_rx(1'b1);
        t_tx(1'b1, 4'h3);
        t_tx(1'b0, 4'hc);
        results();
    end
endmodule : pml_phy_timing_tb

// *** rtl/pml_phy_timing.sv ***
// MII-side timing core: strap latch, transmit and receive latency lines, receive clock.
// Assumes tx_clk_i, the line inputs and the strap pins come from outside the system
// clock domain and pass two flip-flops here; configuration and rx_ready_i are on it.
// Latencies are counted in whole cycles of the system clock.
//
// Notes on behaviour
// [RULE1] Straps are sampled and the strap pins turn into outputs no sooner than 100 us after power-up.
// [RULE2] The outside party holds reset low at least 1 us with the reference clock stable for 1 ms. The bench holds reset low only 4 system cycles (20 ns).
// [RULE3] Switching receive clock sources may stretch a clock phase but never shortens one.
// [RULE4] At 100 Mb/s the first line bit leaves about 4.8 bit times after the first tx_clk rise with enable.
// [RULE5] At 100 Mb/s the line output ends about 4.6 bit times after the closing tx_clk edge.
// [RULE6] At 100 Mb/s carrier sense rises about 14 bit times after the start group arrives.
// [RULE7] Normal receive data latency at 100 Mb/s is about 19 bit times.
// [RULE8] Bit 1 of the configuration register enables fast valid detection, cutting latency to 15.
// [RULE9] Carrier sense falls about 19 bit times after the end group arrives.
// [RULE10] The attached controller updates transmit data and enable on the tx_clk rising edge.
// [RULE11] At 10 Mb/s the device captures transmit data and enable on the tx_clk falling edge.
`timescale 1ns/1ps
module pml_phy_timing
    import pml_pkg::*;
#(
    parameter int unsigned STRAP_CYC = STRAP_DRIVE_CYC,
    parameter int unsigned W = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Configuration
    input wire logic [15:0] sw_strap_ctrl_reg_one_i,
    input wire logic speed_100_i,
    input wire logic rx_recovered_sel_i,
    // Strap pins
    input wire logic [W-1:0] strap_pin_i,
    output logic [W-1:0] strap_pin_o,
    output logic [W-1:0] strap_pin_oe_o,
    output logic [W-1:0] strap_val_o,
    // MII transmit
    input wire logic tx_clk_i,
    input wire logic tx_en_i,
    input wire logic [3:0] txd_i,
    // Line side
    output logic line_tx_o,
    output logic [3:0] line_txd_o,
    input wire logic line_rx_act_i,
    input wire logic [3:0] line_rxd_i,
    // MII receive
    output logic rx_clk_o,
    output logic crs_o,
    output logic rx_dv_o,
    output logic [3:0] rxd_o,
    input wire logic rx_ready_i
);
    // ==========================================================================
    // State
    // ==========================================================================
    // Everything the core remembers sits in one record, so that reset and the
    // register stage always cover all of it together.
    typedef struct packed {
        // Power-up wait and latched straps.
        logic [31:0] por_cnt;
        logic strap_done;
        logic [2*W-1:0] strap_s;
        logic [W-1:0] strap;
        // Input synchronisers; the transmit clock has a third stage to find edges.
        logic [2:0] txc_s;
        logic [1:0] txe_s;
        logic [7:0] txd_s;
        logic [1:0] rxa_s;
        logic [7:0] rxd_s;
        // Latency lines, one entry per system cycle.
        logic [DLY_LEN-1:0] txv_line;
        logic [DLY_LEN*4-1:0] txd_line;
        logic [DLY_LEN-1:0] rxv_line;
        logic [DLY_LEN*4-1:0] rxd_line;
        logic [DLY_LEN-1:0] crs_line;
        // Transmit capture.
        logic tx_act;
        logic [3:0] tx_word;
        // Receive control and two-entry buffer.
        pml_rx_st_t rx_st;
        logic [1:0] buf_v;
        logic [7:0] buf_d;
        // Registered outputs.
        logic line_tx;
        logic [3:0] line_txd;
        logic crs;
        logic rx_dv;
        logic [3:0] rxd;
        // Receive clock generator.
        logic rx_clk;
        logic [7:0] rxc_cnt;
        logic rxc_src;
    } pml_state_t;
    pml_state_t s_q;
    pml_state_t s_d;

    // ==========================================================================
    // Helpers
    // ==========================================================================
    // Entry n-1 of a one-bit latency line: the value put in n cycles before.
    function automatic logic tap(input logic [DLY_LEN-1:0] v, input int unsigned n);
        tap = v[n-1];
    endfunction : tap

    // Entry n-1 of a nibble-wide latency line, aligned with tap.
    function automatic logic [3:0] tap4(input logic [DLY_LEN*4-1:0] v,
                                        input int unsigned n);
        tap4 = v[n*4-1 -: 4];
    endfunction : tap4

    // Pushes one bit into a one-bit latency line.
    function automatic logic [DLY_LEN-1:0] push1(input logic [DLY_LEN-1:0] v, input logic b);
        push1 = {v[DLY_LEN-2:0], b};
    endfunction : push1

    // Pushes one nibble into a nibble-wide latency line.
    function automatic logic [DLY_LEN*4-1:0] push4(input logic [DLY_LEN*4-1:0] v,
                                                   input logic [3:0] d);
        push4 = {v[DLY_LEN*4-5:0], d};
    endfunction : push4

    // Receive latency in cycles for the selected detection mode.
    function automatic int unsigned rx_lat(input logic fast_on);
        if (fast_on) begin
            rx_lat = RX_FAST_CYC;
        end else begin
            rx_lat = RX_DATA_CYC;
        end
    endfunction : rx_lat

    // ==========================================================================
    // Next state
    // ==========================================================================
    logic tx_rise;
    logic tx_fall;
    logic cap_edge;
    logic tx_start_hit;
    logic tx_end_hit;
    logic crs_on_hit;
    logic crs_off_hit;
    logic fast;
    logic rx_take;
    logic [3:0] rx_nib;
    logic [7:0] half_cyc;

    always_comb begin
        s_d = s_q;
        tx_rise = s_q.txc_s[1] & ~s_q.txc_s[2];
        tx_fall = ~s_q.txc_s[1] & s_q.txc_s[2];
        // Taps of the latency lines, read from the current state.
        tx_start_hit = tap(s_q.txv_line, TX_START_CYC);
        tx_end_hit = tap(s_q.txv_line, TX_END_CYC);
        crs_on_hit = tap(s_q.crs_line, CRS_ON_CYC);
        crs_off_hit = tap(s_q.crs_line, CRS_OFF_CYC);
        fast = sw_strap_ctrl_reg_one_i[FAST_VALID_DETECT_BIT];
        rx_take = tap(s_q.rxv_line, rx_lat(fast));
        rx_nib = tap4(s_q.rxd_line, rx_lat(fast));
        // Defaults for the decode results chosen below.
        cap_edge = 1'b0;
        half_cyc = 8'(RXC_HALF_10_CYC);

        // Power-up wait. The strap pins stay inputs until it has run out, so that
        // the board's pull resistors have settled the levels before they are latched.
        s_d.strap_s = {s_q.strap_s[W-1:0], strap_pin_i};
        if (!s_q.strap_done) begin
            s_d.por_cnt = s_q.por_cnt + 32'h1;
            if (s_q.por_cnt >= STRAP_CYC - 1) begin // see [RULE1]
                s_d.strap_done = 1'b1;
                s_d.strap = s_q.strap_s[2*W-1:W];
            end
        end

        // Synchronisers: the first stage feeds only the second.
        s_d.txc_s = {s_q.txc_s[1:0], tx_clk_i};
        s_d.txe_s = {s_q.txe_s[0], tx_en_i};
        s_d.txd_s = {s_q.txd_s[3:0], txd_i};
        s_d.rxa_s = {s_q.rxa_s[0], line_rx_act_i};
        s_d.rxd_s = {s_q.rxd_s[3:0], line_rxd_i};

        // Transmit capture. The controller changes its signals on the rise, so at
        // 10 Mb/s the fall is the edge furthest from any change.
        if (speed_100_i) begin
            cap_edge = tx_rise; // see [RULE4]
        end else begin
            cap_edge = tx_fall; // see [RULE11]
        end
        if (cap_edge) begin
            s_d.tx_act = s_q.txe_s[1];
            s_d.tx_word = s_q.txd_s[7:4];
        end
        s_d.txv_line = push1(s_q.txv_line, s_q.tx_act);
        s_d.txd_line = push4(s_q.txd_line, s_q.tx_word);

        // Start and end use separate taps so that each keeps its own latency.
        // Latencies are whole system cycles, so fractions of a bit time are lost.
        if (s_q.tx_act && tx_start_hit) begin // see [RULE4]
            s_d.line_tx = 1'b1;
        end else if (!tx_end_hit) begin // see [RULE5]
            s_d.line_tx = 1'b0;
        end
        s_d.line_txd = tap4(s_q.txd_line, TX_START_CYC);

        // Receive latency lines, fed from the synchronised line inputs.
        s_d.crs_line = push1(s_q.crs_line, s_q.rxa_s[1]);
        s_d.rxv_line = push1(s_q.rxv_line, s_q.rxa_s[1]);
        s_d.rxd_line = push4(s_q.rxd_line, s_q.rxd_s[7:4]);

        // Carrier sense follows the line activity with separate on and off delays.
        case (s_q.rx_st)
            PML_RX_IDLE: begin
                // Waiting for a start group to come out of the on delay.
                if (crs_on_hit) begin // see [RULE6]
                    s_d.crs = 1'b1;
                    s_d.rx_st = PML_RX_PKT;
                end
            end
            PML_RX_PKT: begin
                // Activity has dropped at the on tap; the off delay runs on.
                if (!crs_on_hit) begin
                    s_d.rx_st = PML_RX_TAIL;
                end
            end
            PML_RX_TAIL: begin
                // The end group has come out of the longer off delay.
                if (!crs_off_hit) begin // see [RULE9]
                    s_d.crs = 1'b0;
                    s_d.rx_st = PML_RX_IDLE;
                end
            end
            default: begin
                s_d.rx_st = PML_RX_IDLE;
            end
        endcase

        // Two-entry buffer: a receiver stall holds words rather than dropping them.
        // Only a third word that arrives while both entries are full is lost.
        if (rx_ready_i && s_q.buf_v[0]) begin
            s_d.buf_v = {1'b0, s_q.buf_v[1]};
            s_d.buf_d = {4'h0, s_q.buf_d[7:4]};
        end
        if (rx_take) begin // see [RULE7] see [RULE8]
            if (!s_d.buf_v[0]) begin
                s_d.buf_v[0] = 1'b1;
                s_d.buf_d[3:0] = rx_nib;
            end else if (!s_d.buf_v[1]) begin
                s_d.buf_v[1] = 1'b1;
                s_d.buf_d[7:4] = rx_nib;
            end
        end
        s_d.rx_dv = s_q.buf_v[0];
        s_d.rxd = s_q.buf_d[3:0];

        // Receive clock. A change of source waits for the end of a low phase and
        // then stretches it, so neither phase is ever cut short.
        if (speed_100_i) begin
            half_cyc = 8'(RXC_HALF_100_CYC);
        end else begin
            half_cyc = 8'(RXC_HALF_10_CYC);
        end
        if (s_q.rxc_cnt >= half_cyc - 8'h1) begin // see [RULE3]
            s_d.rxc_cnt = 8'h0;
            if (s_q.rxc_src != rx_recovered_sel_i && !s_q.rx_clk) begin
                s_d.rxc_src = rx_recovered_sel_i;
            end else begin
                s_d.rx_clk = ~s_q.rx_clk;
            end
        end else begin
            s_d.rxc_cnt = s_q.rxc_cnt + 8'h1;
        end
    end

    // ==========================================================================
    // Register stage
    // ==========================================================================
    // Reset is synchronous and clears every field, so the power-up wait restarts.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================================
    // Outputs
    // ==========================================================================
    // Every output is a bare register bit; nothing is decoded after the flip-flops.
    // Strap pins.
    assign strap_pin_o = s_q.strap;
    assign strap_pin_oe_o = {W{s_q.strap_done}};
    assign strap_val_o = s_q.strap;

    // Line side.
    assign line_tx_o = s_q.line_tx;
    assign line_txd_o = s_q.line_txd;

    // MII receive.
    assign rx_clk_o = s_q.rx_clk;
    assign crs_o = s_q.crs;
    assign rx_dv_o = s_q.rx_dv;
    assign rxd_o = s_q.rxd;
endmodule : pml_phy_timing

// *** rtl/pml_pkg.sv ***
// Constants for the MII-side timing block of a 10/100 PHY model.
// Assumes a 200 MHz system clock; all times are turned into clock counts here.
package pml_pkg;
    // ==========================================================================
    // Clock and bit times
    // ==========================================================================
    localparam int unsigned SYS_CLK_PS = 5000;
    localparam int unsigned BIT_TIME_PS = 10000;
    // ==========================================================================
    // Power-up and reset
    // ==========================================================================
    localparam int unsigned STRAP_DRIVE_US = 100;
    localparam int unsigned STRAP_DRIVE_CYC = (STRAP_DRIVE_US * 1000000) / SYS_CLK_PS;
    localparam int unsigned RESET_MIN_US = 1;
    localparam int unsigned RESET_MIN_CYC = (RESET_MIN_US * 1000000 + SYS_CLK_PS - 1) / SYS_CLK_PS;
    // ==========================================================================
    // Latencies in tenths of a bit time
    // ==========================================================================
    localparam int unsigned TX_START_TBIT = 48;
    localparam int unsigned TX_END_TBIT = 46;
    localparam int unsigned CRS_ON_TBIT = 140;
    localparam int unsigned RX_DATA_TBIT = 190;
    localparam int unsigned RX_FAST_TBIT = 150;
    localparam int unsigned CRS_OFF_TBIT = 190;
    localparam int unsigned TX_START_CYC = (TX_START_TBIT * BIT_TIME_PS) / (10 * SYS_CLK_PS);
    localparam int unsigned TX_END_CYC = (TX_END_TBIT * BIT_TIME_PS) / (10 * SYS_CLK_PS);
    localparam int unsigned CRS_ON_CYC = (CRS_ON_TBIT * BIT_TIME_PS) / (10 * SYS_CLK_PS);
    localparam int unsigned RX_DATA_CYC = (RX_DATA_TBIT * BIT_TIME_PS) / (10 * SYS_CLK_PS);
    localparam int unsigned RX_FAST_CYC = (RX_FAST_TBIT * BIT_TIME_PS) / (10 * SYS_CLK_PS);
    localparam int unsigned CRS_OFF_CYC = (CRS_OFF_TBIT * BIT_TIME_PS) / (10 * SYS_CLK_PS);
    localparam int unsigned DLY_LEN = 64;
    // ==========================================================================
    // Configuration register field
    // ==========================================================================
    localparam logic [15:0] SW_STRAP_CTRL_REG_ONE_ADDR = 16'h0009;
    localparam int unsigned FAST_VALID_DETECT_BIT = 1;
    // ==========================================================================
    // Receive clock phases in system cycles
    // ==========================================================================
    localparam int unsigned RXC_HALF_100_CYC = 4;
    localparam int unsigned RXC_HALF_10_CYC = 40;
    typedef enum logic [1:0] {PML_RX_IDLE, PML_RX_PKT, PML_RX_TAIL} pml_rx_st_t;
endpackage : pml_pkg
